//--- core/lsm_defs.vh
// Register map, field layout and reset values of the clock loss monitor
`ifndef LSM_DEFS_VH
`define LSM_DEFS_VH
`define LSM_OFF_STS      8'h00
`define LSM_OFF_EVENT    8'h04
`define LSM_OFF_QUAL     8'h08
`define LSM_OFF_WINDOW   8'h0c
`define LSM_OFF_THRESH   8'h10
`define LSM_OFF_NOMINAL  8'h14
`define LSM_OFF_SYSDIV   8'h18
`define LSM_OFF_INT_STS  8'h1c
`define LSM_OFF_INT_MASK 8'h20
`define LSM_OFF_LASTCNT  8'h24
`define LSM_STS_LOS_BIT  0
`define LSM_STS_INV_BIT  1
`define LSM_EVT_LOS_BIT  0
`define LSM_QUAL_GOOD_HI 7
`define LSM_QUAL_GOOD_LO 4
`define LSM_QUAL_FAIL_HI 3
`define LSM_QUAL_FAIL_LO 0
`define LSM_WIN_DIV_HI   7
`define LSM_WIN_DIV_LO   3
`define LSM_WIN_MASK_BIT 0
`define LSM_THR_ACC_HI   28
`define LSM_THR_ACC_LO   16
`define LSM_THR_REJ_HI   12
`define LSM_THR_REJ_LO   0
`define LSM_NOM_HI       12
`define LSM_NOM_LO       0
`define LSM_SDIV_HI      4
`define LSM_SDIV_LO      0
`define LSM_INT_DISQ_BIT 0
`define LSM_INT_QUAL_BIT 1
`define LSM_INT_REJ_BIT  2
`define LSM_RST_DIV      5'h00
`define LSM_RST_MASK     1'h0
`define LSM_RST_MARGIN   13'h0000
`define LSM_RST_NOM      13'h0000
`define LSM_RST_TIMES    4'h0
`define LSM_RST_SDIV     5'h0c
`define LSM_RST_LOS      1'h1
`define LSM_RST_INV      1'h1
`define LSM_RST_EVT      1'h1
`define LSM_RST_INT      3'h0
`define LSM_CNT_MAX      14'h3fff
`endif

//--- core/lsm_sysdiv.v
// System time base divider: one-cycle tick every sys_div_int clocks
`timescale 1ns/1ps
`default_nettype none
`include "lsm_defs.vh"
module lsm_sysdiv (
  input  wire       sys_clk,     // Clock
  input  wire       rst,         // Synchronous reset
  input  wire       restart,     // Restart the divider phase
  input  wire [4:0] sys_div_int, // Divide integer
  output wire       sys_tick     // One-cycle time base pulse
);
  reg  [4:0] cnt_r;
  reg        tick_r;
  wire [4:0] lim;
  // Zero would stall the time base, so it divides by one
  assign lim = (sys_div_int == 5'h00) ? 5'h01 : sys_div_int;
  assign sys_tick = tick_r;
  always @(posedge sys_clk) begin
    if (rst || restart) begin
      cnt_r  <= 5'h00;
      tick_r <= 1'b0;
    end else if (cnt_r >= lim - 5'h01) begin
      cnt_r  <= 5'h00;
      tick_r <= 1'b1;
    end else begin
      cnt_r  <= cnt_r + 5'h01;
      tick_r <= 1'b0;
    end
  end
endmodule
`default_nettype wire

//--- core/lsm_windiv.v
// Monitored clock divider: pulses at the end of each measurement window
`timescale 1ns/1ps
`default_nettype none
`include "lsm_defs.vh"
module lsm_windiv (
  input  wire       sys_clk,   // Clock
  input  wire       rst,       // Synchronous reset
  input  wire       restart,   // Restart the window phase
  input  wire       mon_clk,   // Monitored clock, sampled
  input  wire [4:0] div_ratio, // Window length in monitored periods
  output wire       win_end    // One-cycle end-of-window pulse
);
  reg        mon_q_r;
  reg  [4:0] edge_cnt_r;
  reg        win_end_r;
  wire [4:0] lim;
  wire       rise;
  assign lim = (div_ratio <= 5'h01) ? 5'h01 : div_ratio;
  assign rise = mon_clk & ~mon_q_r;
  assign win_end = win_end_r;
  always @(posedge sys_clk) begin
    if (rst || restart) begin
      // Seed with the live level so a clock that is already high is not taken for an edge
      mon_q_r    <= mon_clk;
      edge_cnt_r <= 5'h00;
      win_end_r  <= 1'b0;
    end else begin
      mon_q_r   <= mon_clk;
      win_end_r <= 1'b0;
      if (rise) begin
        if (edge_cnt_r + 5'h01 >= lim) begin
          edge_cnt_r <= 5'h00;
          win_end_r  <= 1'b1;
        end else begin
          edge_cnt_r <= edge_cnt_r + 5'h01;
        end
      end
    end
  end
endmodule
`default_nettype wire

//--- core/lsm_top.v
// Clock loss-of-signal monitor with register port and interrupt
//
// Implementation choices: the plain strobed port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "lsm_defs.vh"
module lsm_top (
  input  wire        sys_clk,     // 125 MHz clock
  input  wire        rst,         // Synchronous reset, active high
  input  wire        mon_clk,     // Monitored reference clock
  input  wire [7:0]  reg_addr,    // Register byte address
  input  wire [31:0] reg_wdata,   // Write data
  input  wire        reg_wr,      // Write strobe
  input  wire        reg_rd,      // Read strobe
  output wire [31:0] reg_rdata,   // Read data, cycle after strobe
  output wire        los_sts,     // Loss-of-signal status
  output wire        ref_invalid, // Reference invalid flag
  output wire        irq          // Level interrupt
);

  function [13:0] lsm_absdiff;
    input [13:0] a;
    input [13:0] b;
    begin
      if (a > b) begin
        lsm_absdiff = a - b;
      end else begin
        lsm_absdiff = b - a;
      end
    end
  endfunction

  function [3:0] lsm_lim;
    input [3:0] v;
    begin
      lsm_lim = (v == 4'h0) ? 4'h1 : v;
    end
  endfunction

  // Configuration
  reg  [4:0]  div_ratio_r;
  reg         fail_mask_r;
  reg  [12:0] acc_margin_r;
  reg  [12:0] rej_margin_r;
  reg  [12:0] nom_num_r;
  reg  [3:0]  good_times_r;
  reg  [3:0]  fail_times_r;
  reg  [4:0]  sys_div_r;
  reg  [2:0]  int_mask_r;
  // State
  reg  [2:0]  int_sts_r;
  reg         los_evt_r;
  reg         los_r;
  reg         inv_r;
  reg         irq_r;
  reg  [13:0] cnt_r;
  reg  [13:0] last_cnt_r;
  reg  [3:0]  good_cnt_r;
  reg  [3:0]  fail_cnt_r;
  reg         armed_r;
  reg         restart_r;
  reg  [31:0] rdata_r;
  // Next values
  reg  [13:0] cnt_nxt;
  reg  [13:0] last_cnt_nxt;
  reg  [3:0]  good_cnt_nxt;
  reg  [3:0]  fail_cnt_nxt;
  reg         armed_nxt;
  reg         los_nxt;
  reg         ev_disq;
  reg         ev_qual;
  reg         ev_rej;
  reg  [31:0] rdata_nxt;

  // Next values of configuration and events
  reg  [4:0]  div_ratio_nxt;
  reg         fail_mask_nxt;
  reg  [12:0] acc_margin_nxt;
  reg  [12:0] rej_margin_nxt;
  reg  [12:0] nom_num_nxt;
  reg  [3:0]  good_times_nxt;
  reg  [3:0]  fail_times_nxt;
  reg  [4:0]  sys_div_nxt;
  reg  [2:0]  int_mask_nxt;
  reg  [2:0]  int_sts_nxt;
  reg         los_evt_nxt;
  reg         irq_nxt;

  wire        sys_tick;
  wire        win_end;
  wire        mon_off;
  wire [13:0] dev;
  wire        win_acc;
  wire        win_rej;
  wire        wr_hit_cfg;
  wire [2:0]  int_set;
  wire [2:0]  int_clr;
  wire        evt_clr;

  lsm_sysdiv u_sysdiv (
    .sys_clk     (sys_clk),
    .rst         (rst),
    .restart     (restart_r),
    .sys_div_int (sys_div_r),
    .sys_tick    (sys_tick)
  );

  lsm_windiv u_windiv (
    .sys_clk   (sys_clk),
    .rst       (rst),
    .restart   (restart_r),
    .mon_clk   (mon_clk),
    .div_ratio (div_ratio_r),
    .win_end   (win_end)
  );

  assign mon_off = (nom_num_r == 13'h0000);
  assign dev     = lsm_absdiff(cnt_r, {1'b0, nom_num_r});
  assign win_acc = (dev <= {1'b0, acc_margin_r});
  assign win_rej = (dev > {1'b0, rej_margin_r});

  // Any change to timing setup restarts measurement; a half window would mislead
  assign wr_hit_cfg = reg_wr && ((reg_addr == `LSM_OFF_WINDOW) ||
                                 (reg_addr == `LSM_OFF_THRESH) ||
                                 (reg_addr == `LSM_OFF_NOMINAL) ||
                                 (reg_addr == `LSM_OFF_SYSDIV));

  // Window evaluation
  always @* begin
    cnt_nxt      = cnt_r;
    last_cnt_nxt = last_cnt_r;
    good_cnt_nxt = good_cnt_r;
    fail_cnt_nxt = fail_cnt_r;
    armed_nxt    = armed_r;
    los_nxt      = los_r;
    ev_disq      = 1'b0;
    ev_qual      = 1'b0;
    ev_rej       = 1'b0;
    if (mon_off) begin
      cnt_nxt      = 14'h0000;
      good_cnt_nxt = 4'h0;
      fail_cnt_nxt = 4'h0;
      armed_nxt    = 1'b0;
      los_nxt      = 1'b1;
    end else if (restart_r) begin
      cnt_nxt      = 14'h0000;
      good_cnt_nxt = 4'h0;
      fail_cnt_nxt = 4'h0;
      armed_nxt    = 1'b0;
    end else if (win_end) begin
      // First window end after a restart only opens a window
      cnt_nxt   = sys_tick ? 14'h0001 : 14'h0000;
      armed_nxt = 1'b1;
      if (armed_r) begin
        last_cnt_nxt = cnt_r;
        if (win_rej) begin
          ev_rej       = 1'b1;
          good_cnt_nxt = 4'h0;
          if (fail_cnt_r + 4'h1 >= lsm_lim(fail_times_r)) begin
            fail_cnt_nxt = 4'h0;
            if (!los_r) begin
              ev_disq = 1'b1;
            end
            los_nxt = 1'b1;
          end else begin
            fail_cnt_nxt = fail_cnt_r + 4'h1;
          end
        end else if (win_acc) begin
          if (good_cnt_r + 4'h1 >= lsm_lim(good_times_r)) begin
            good_cnt_nxt = 4'h0;
            fail_cnt_nxt = 4'h0;
            if (los_r) begin
              ev_qual = 1'b1;
            end
            los_nxt = 1'b0;
          end else begin
            good_cnt_nxt = good_cnt_r + 4'h1;
          end
        end
        // Neither accepted nor rejected: counters left as they are
      end
    end else if (sys_tick && (cnt_r != `LSM_CNT_MAX)) begin
      // Saturate so a dead monitored clock cannot wrap into the accept band
      cnt_nxt = cnt_r + 14'h0001;
    end
  end

  always @(posedge sys_clk) begin
    if (rst) begin
      cnt_r      <= 14'h0000;
      last_cnt_r <= 14'h0000;
      good_cnt_r <= 4'h0;
      fail_cnt_r <= 4'h0;
      armed_r    <= 1'b0;
      restart_r  <= 1'b0;
      los_r      <= `LSM_RST_LOS;
      inv_r      <= `LSM_RST_INV;
    end else begin
      cnt_r      <= cnt_nxt;
      last_cnt_r <= last_cnt_nxt;
      good_cnt_r <= good_cnt_nxt;
      fail_cnt_r <= fail_cnt_nxt;
      armed_r    <= armed_nxt;
      restart_r  <= wr_hit_cfg;
      los_r      <= los_nxt;
      inv_r      <= los_nxt & ~fail_mask_r;
    end
  end

  // Configuration writes; unmapped offsets fall through and change nothing
  // A divide ratio of all ones is stored as written: keeping it out is up to software
  always @* begin
    div_ratio_nxt  = div_ratio_r;
    fail_mask_nxt  = fail_mask_r;
    acc_margin_nxt = acc_margin_r;
    rej_margin_nxt = rej_margin_r;
    nom_num_nxt    = nom_num_r;
    good_times_nxt = good_times_r;
    fail_times_nxt = fail_times_r;
    sys_div_nxt    = sys_div_r;
    int_mask_nxt   = int_mask_r;
    if (reg_wr) begin
      if (reg_addr == `LSM_OFF_QUAL) begin
        good_times_nxt = reg_wdata[`LSM_QUAL_GOOD_HI:`LSM_QUAL_GOOD_LO];
        fail_times_nxt = reg_wdata[`LSM_QUAL_FAIL_HI:`LSM_QUAL_FAIL_LO];
      end else if (reg_addr == `LSM_OFF_WINDOW) begin
        div_ratio_nxt = reg_wdata[`LSM_WIN_DIV_HI:`LSM_WIN_DIV_LO];
        fail_mask_nxt = reg_wdata[`LSM_WIN_MASK_BIT];
      end else if (reg_addr == `LSM_OFF_THRESH) begin
        acc_margin_nxt = reg_wdata[`LSM_THR_ACC_HI:`LSM_THR_ACC_LO];
        rej_margin_nxt = reg_wdata[`LSM_THR_REJ_HI:`LSM_THR_REJ_LO];
      end else if (reg_addr == `LSM_OFF_NOMINAL) begin
        nom_num_nxt = reg_wdata[`LSM_NOM_HI:`LSM_NOM_LO];
      end else if (reg_addr == `LSM_OFF_SYSDIV) begin
        sys_div_nxt = reg_wdata[`LSM_SDIV_HI:`LSM_SDIV_LO];
      end else if (reg_addr == `LSM_OFF_INT_MASK) begin
        int_mask_nxt = reg_wdata[2:0];
      end
    end
  end

  always @(posedge sys_clk) begin
    if (rst) begin
      div_ratio_r  <= `LSM_RST_DIV;
      fail_mask_r  <= `LSM_RST_MASK;
      acc_margin_r <= `LSM_RST_MARGIN;
      rej_margin_r <= `LSM_RST_MARGIN;
      nom_num_r    <= `LSM_RST_NOM;
      good_times_r <= `LSM_RST_TIMES;
      fail_times_r <= `LSM_RST_TIMES;
      sys_div_r    <= `LSM_RST_SDIV;
      int_mask_r   <= `LSM_RST_INT;
    end else begin
      div_ratio_r  <= div_ratio_nxt;
      fail_mask_r  <= fail_mask_nxt;
      acc_margin_r <= acc_margin_nxt;
      rej_margin_r <= rej_margin_nxt;
      nom_num_r    <= nom_num_nxt;
      good_times_r <= good_times_nxt;
      fail_times_r <= fail_times_nxt;
      sys_div_r    <= sys_div_nxt;
      int_mask_r   <= int_mask_nxt;
    end
  end

  // Sticky events: a set in the same cycle as a clear wins
  assign int_set[`LSM_INT_DISQ_BIT] = ev_disq;
  assign int_set[`LSM_INT_QUAL_BIT] = ev_qual;
  assign int_set[`LSM_INT_REJ_BIT]  = ev_rej;
  assign int_clr = (reg_wr && (reg_addr == `LSM_OFF_INT_STS)) ? reg_wdata[2:0] : 3'h0;
  assign evt_clr = reg_wr && (reg_addr == `LSM_OFF_EVENT) && reg_wdata[`LSM_EVT_LOS_BIT];

  // Loss event is re-set from both the present and the next loss level, so a
  // clear that lands on the cycle in which loss ends cannot drop a live loss
  always @* begin
    int_sts_nxt = (int_sts_r & ~int_clr) | int_set;
    los_evt_nxt = (los_evt_r & ~evt_clr) | los_r | los_nxt;
    irq_nxt     = |(int_sts_nxt & int_mask_r);
  end

  always @(posedge sys_clk) begin
    if (rst) begin
      int_sts_r <= `LSM_RST_INT;
      los_evt_r <= `LSM_RST_EVT;
      irq_r     <= 1'b0;
    end else begin
      int_sts_r <= int_sts_nxt;
      los_evt_r <= los_evt_nxt;
      irq_r     <= irq_nxt;
    end
  end

  // Read path
  always @* begin
    rdata_nxt = 32'h0000_0000;
    if (reg_addr == `LSM_OFF_STS) begin
      rdata_nxt[`LSM_STS_LOS_BIT] = los_r;
      rdata_nxt[`LSM_STS_INV_BIT] = inv_r;
    end else if (reg_addr == `LSM_OFF_EVENT) begin
      rdata_nxt[`LSM_EVT_LOS_BIT] = los_evt_r;
    end else if (reg_addr == `LSM_OFF_QUAL) begin
      rdata_nxt[`LSM_QUAL_GOOD_HI:`LSM_QUAL_GOOD_LO] = good_times_r;
      rdata_nxt[`LSM_QUAL_FAIL_HI:`LSM_QUAL_FAIL_LO] = fail_times_r;
    end else if (reg_addr == `LSM_OFF_WINDOW) begin
      rdata_nxt[`LSM_WIN_DIV_HI:`LSM_WIN_DIV_LO] = div_ratio_r;
      rdata_nxt[`LSM_WIN_MASK_BIT] = fail_mask_r;
    end else if (reg_addr == `LSM_OFF_THRESH) begin
      rdata_nxt[`LSM_THR_ACC_HI:`LSM_THR_ACC_LO] = acc_margin_r;
      rdata_nxt[`LSM_THR_REJ_HI:`LSM_THR_REJ_LO] = rej_margin_r;
    end else if (reg_addr == `LSM_OFF_NOMINAL) begin
      rdata_nxt[`LSM_NOM_HI:`LSM_NOM_LO] = nom_num_r;
    end else if (reg_addr == `LSM_OFF_SYSDIV) begin
      rdata_nxt[`LSM_SDIV_HI:`LSM_SDIV_LO] = sys_div_r;
    end else if (reg_addr == `LSM_OFF_INT_STS) begin
      rdata_nxt[2:0] = int_sts_r;
    end else if (reg_addr == `LSM_OFF_INT_MASK) begin
      rdata_nxt[2:0] = int_mask_r;
    end else if (reg_addr == `LSM_OFF_LASTCNT) begin
      rdata_nxt[13:0] = last_cnt_r;
    end
  end

  always @(posedge sys_clk) begin
    if (rst) begin
      rdata_r <= 32'h0000_0000;
    end else if (reg_rd) begin
      rdata_r <= rdata_nxt;
    end else begin
      rdata_r <= 32'h0000_0000;
    end
  end

  assign reg_rdata   = rdata_r;
  assign los_sts     = los_r;
  assign ref_invalid = inv_r;
  assign irq         = irq_r;

endmodule
`default_nettype wire

//--- sim/lsm_assertions.sv
// Port-level checker for the clock loss monitor
`timescale 1ns/1ps
`default_nettype none
`include "lsm_defs.vh"
module lsm_assertions (
  input wire logic        sys_clk,     // Clock
  input wire logic        rst,         // Reset
  input wire logic        mon_clk,     // Monitored clock
  input wire logic [7:0]  reg_addr,    // Address
  input wire logic [31:0] reg_wdata,   // Write data
  input wire logic        reg_wr,      // Write strobe
  input wire logic        reg_rd,      // Read strobe
  input wire logic [31:0] reg_rdata,   // Read data
  input wire logic        los_sts,     // Loss status
  input wire logic        ref_invalid, // Invalid flag
  input wire logic        irq          // Interrupt
);
  logic [7:0] win_r;
  logic [4:0] sdiv_r;
  logic       nomz_r;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  // Configuration shadows rebuilt from bus writes, since only ports are visible
  always @(posedge sys_clk) begin
    if (rst) begin
      win_r  <= 8'h00;
      sdiv_r <= 5'h0c;
      nomz_r <= 1'b1;
    end else if (reg_wr) begin
      if (reg_addr == `LSM_OFF_WINDOW)
        win_r <= reg_wdata[7:0];
      if (reg_addr == `LSM_OFF_SYSDIV)
        sdiv_r <= reg_wdata[4:0];
      if (reg_addr == `LSM_OFF_NOMINAL)
        nomz_r <= (reg_wdata[12:0] == 13'h0000);
    end
  end
  a_inv_follows_los: assert property ($stable(win_r[0]) && $stable(los_sts)
    |-> ref_invalid == (los_sts & ~win_r[0])) else $error("ref_invalid mismatch");
  a_inv_needs_los: assert property (ref_invalid |-> los_sts || $past(los_sts))
    else $error("ref_invalid without loss");
  a_reset_values: assert property ($fell(rst) |-> los_sts && ref_invalid && !irq)
    else $error("wrong values after reset");
  a_sts_read: assert property ($past(reg_rd) && $past(reg_addr) == `LSM_OFF_STS
    |-> reg_rdata == {30'h0, $past(ref_invalid), $past(los_sts)}) else $error("status read");
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data outside read cycle");
  a_nominal_zero: assert property (nomz_r && $past(nomz_r) && $past(nomz_r, 2)
    |-> los_sts) else $error("monitor disabled but loss low");
  a_event_sticky: assert property (reg_rd && reg_addr == `LSM_OFF_EVENT && $past(los_sts)
    |=> reg_rdata[0]) else $error("event bit lost during loss");
  a_sysdiv_read: assert property ($past(reg_rd) && $past(reg_addr) == `LSM_OFF_SYSDIV
    |-> reg_rdata == {27'h0, $past(sdiv_r)}) else $error("divider read");
  a_window_read: assert property ($past(reg_rd) && $past(reg_addr) == `LSM_OFF_WINDOW
    |-> reg_rdata == {24'h0, $past(win_r[7:3]), 2'b00, $past(win_r[0])})
    else $error("window read");
endmodule
bind lsm_top lsm_assertions u_chk (.sys_clk(sys_clk), .rst(rst), .mon_clk(mon_clk),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .los_sts(los_sts), .ref_invalid(ref_invalid), .irq(irq));
`default_nettype wire

//--- sim/lsm_mon_model.sv
// Behavioural source of the monitored reference clock
`timescale 1ns/1ps
`default_nettype none
module lsm_mon_model (
  input  wire logic       sys_clk, // Bench clock
  input  wire logic [7:0] half,    // Half period in sys_clk cycles
  output var  logic       mon_clk  // Monitored clock
);
  logic [7:0] cnt_r;
  initial cnt_r = 8'h00;
  initial mon_clk = 1'b0;
  // Edges on sys_clk edges keep every period an exact multiple of the sys_clk cycle (2 * half)
  always @(posedge sys_clk) begin
    if (cnt_r + 8'h01 >= half) begin
      cnt_r   <= 8'h00;
      mon_clk <= ~mon_clk;
    end else begin
      cnt_r <= cnt_r + 8'h01;
    end
  end
endmodule
`default_nettype wire

//--- sim/testbench.sv
// Self-checking bench for the clock loss monitor
`timescale 1ns/1ps
`default_nettype none
`include "lsm_defs.vh"
module testbench;
  logic        sys_clk;
  logic        rst;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [7:0]  half;
  wire         mon_clk;
  wire  [31:0] reg_rdata;
  wire         los_sts;
  wire         ref_invalid;
  wire         irq;
  integer      error_cnt;
  integer      num_checks;

  lsm_top DUT (.sys_clk(sys_clk), .rst(rst), .mon_clk(mon_clk), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .los_sts(los_sts), .ref_invalid(ref_invalid), .irq(irq));
  lsm_mon_model u_mon (.sys_clk(sys_clk), .half(half), .mon_clk(mon_clk));

  initial sys_clk = 1'b0;
  always #4 sys_clk = ~sys_clk;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks = num_checks + 1;
    if (got !== exp) begin
      error_cnt = error_cnt + 1;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    // Let the write and the one-cycle lag of irq behind a mask change settle
    @(posedge sys_clk);
    #1;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge sys_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, exp);
  endtask
  // Bounded wait: a decision takes a few windows of at most 160 cycles
  task automatic wait_los(input logic v);
    int i;
    i = 0;
    while (los_sts !== v && i < 2000) begin
      @(posedge sys_clk);
      #1;
      i = i + 1;
    end
    chk({31'h0, los_sts}, {31'h0, v});
  endtask
  task automatic stop_test;
    $display("errors=%0d checks=%0d", error_cnt, num_checks);
    if (error_cnt == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  initial begin
    #400000;
    error_cnt = error_cnt + 1;
    stop_test;
  end

  initial begin
    error_cnt  = 0;
    num_checks = 0;
    rst        = 1'b1;
    reg_addr   = 8'h00;
    reg_wdata  = 32'h0;
    reg_wr     = 1'b0;
    reg_rd     = 1'b0;
    half       = 8'd60;
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    rd(`LSM_OFF_STS, 32'h3);
    rd(`LSM_OFF_EVENT, 32'h1);
    rd(`LSM_OFF_SYSDIV, 32'hc);
    rd(`LSM_OFF_NOMINAL, 32'h0);
    rd(8'h3c, 32'h0);
    wr(`LSM_OFF_EVENT, 32'h1);
    rd(`LSM_OFF_EVENT, 32'h1);
    wr(`LSM_OFF_WINDOW, 32'hffffff57);
    rd(`LSM_OFF_WINDOW, 32'h51);
    chk({31'h0, ref_invalid}, 32'h0);
    wr(`LSM_OFF_THRESH, 32'hffffffff);
    rd(`LSM_OFF_THRESH, 32'h1fff1fff);
    wr(`LSM_OFF_NOMINAL, 32'hffffffff);
    rd(`LSM_OFF_NOMINAL, 32'h1fff);
    wr(`LSM_OFF_SYSDIV, 32'hffffffea);
    rd(`LSM_OFF_SYSDIV, 32'ha);
    // Tick every 12 clocks, 120-clock window: ten ticks
    wr(`LSM_OFF_SYSDIV, 32'hc);
    wr(`LSM_OFF_THRESH, 32'h00020003);
    wr(`LSM_OFF_QUAL, 32'h22);
    wr(`LSM_OFF_INT_MASK, 32'h7);
    wr(`LSM_OFF_NOMINAL, 32'ha);
    wr(`LSM_OFF_WINDOW, 32'h08);
    wait_los(1'b0);
    rd(`LSM_OFF_INT_STS, 32'h2);
    chk({31'h0, irq}, 32'h1);
    rd(`LSM_OFF_LASTCNT, 32'ha);
    chk({31'h0, ref_invalid}, 32'h0);
    wr(`LSM_OFF_INT_STS, 32'h7);
    chk({31'h0, irq}, 32'h0);
    wr(`LSM_OFF_EVENT, 32'h1);
    rd(`LSM_OFF_EVENT, 32'h0);
    // Thirteen ticks: outside accept, inside reject
    half <= 8'd78;
    repeat (800) @(posedge sys_clk);
    rd(`LSM_OFF_LASTCNT, 32'hd);
    rd(`LSM_OFF_INT_STS, 32'h0);
    chk({31'h0, los_sts}, 32'h0);
    // Five ticks: rejected, interrupt masked off
    wr(`LSM_OFF_INT_MASK, 32'h0);
    half <= 8'd30;
    wait_los(1'b1);
    rd(`LSM_OFF_INT_STS, 32'h5);
    chk({31'h0, irq}, 32'h0);
    chk({31'h0, ref_invalid}, 32'h1);
    wr(`LSM_OFF_INT_MASK, 32'h1);
    chk({31'h0, irq}, 32'h1);
    wr(`LSM_OFF_INT_STS, 32'h1);
    chk({31'h0, irq}, 32'h0);
    rd(`LSM_OFF_EVENT, 32'h1);
    // Ratio two: two short periods make one ten-tick window
    wr(`LSM_OFF_WINDOW, 32'h10);
    wait_los(1'b0);
    rd(`LSM_OFF_LASTCNT, 32'ha);
    wr(`LSM_OFF_WINDOW, 32'h11);
    wr(`LSM_OFF_NOMINAL, 32'h0);
    wait_los(1'b1);
    chk({31'h0, ref_invalid}, 32'h0);
    stop_test;
  end
endmodule
`default_nettype wire
